// ===== hw/pplcm_top.sv
`timescale 1ns/10ps
module pplcm_top
  import pplcm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // test control pins
  input wire logic link_check_enable_in,
  input wire logic chipSelect_n,
  // test input pins, groups a to d
  input pplcm_pins_t pins,
  // test output pins
  output pplcm_results_t resultOut,
  output logic [DQ_W-1:0] dqOe,
  output logic [3:0] strobeOe,
  // device controls
  output logic link_check_mode,
  output logic terminationEnable,
  output pplcm_ctl_t ctlOut
);

  // ==========================================================
  // declarations
  logic enSync1_reg;
  logic enSync2_reg;
  logic termSync1_reg;
  logic termSync2_reg;
  logic [CNT_W-1:0] entryCnt_reg;
  logic [CNT_W-1:0] entryCnt_next;
  logic mode_reg;
  logic mode_next;
  logic termEnable_reg;
  logic resetNeeded_reg;
  logic outputDrive;
  pplcm_results_t termResults;

  // ==========================================================
  // synchronisers for the slow control pins
  // the enable resets low so a floating pin never starts the mode
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      enSync1_reg <= 1'b0;
      enSync2_reg <= 1'b0;
    end
    else
    begin
      enSync1_reg <= link_check_enable_in;
      enSync2_reg <= enSync1_reg;
    end
  end

  // termination request is a normal-mode pin, synchronised the same way
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      termSync1_reg <= 1'b0;
      termSync2_reg <= 1'b0;
    end
    else
    begin
      termSync1_reg <= pins.termination_control_in;
      termSync2_reg <= termSync1_reg;
    end
  end

  // ==========================================================
  // entry delay: count whole cycles of steady enable before entry
  always_comb
  begin
    entryCnt_next = entryCnt_reg;
    mode_next = mode_reg;
    if (!enSync2_reg)
    begin
      // enable may drop at any time; leave at once
      entryCnt_next = '0;
      mode_next = 1'b0;
    end
    else if (entryCnt_reg != ENTRY_COUNT)
    begin
      entryCnt_next = entryCnt_reg + CNT_W'(1);
    end
    else
    begin
      mode_next = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      entryCnt_reg <= '0;
      mode_reg <= MODE_RST;
    end
    else
    begin
      entryCnt_reg <= entryCnt_next;
      mode_reg <= mode_next;
    end
  end

  // ==========================================================
  // termination: off as soon as the enable is seen, well before entry
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      termEnable_reg <= 1'b0;
    end
    else
    begin
      // outside the mode termination follows its pin only while the enable is seen low
      termEnable_reg <= termSync2_reg & ~enSync2_reg & ~mode_next;
    end
  end

  // ==========================================================
  // exit bookkeeping: array contents and state are lost on exit
  // only a full device reset clears the flag
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      resetNeeded_reg <= 1'b0;
    end
    else if (mode_reg && !mode_next)
    begin
      resetNeeded_reg <= 1'b1;
    end
  end

  // ==========================================================
  // device controls straight from flip-flops, except normal enable, gated from two of them
  assign link_check_mode = mode_reg;
  assign terminationEnable = termEnable_reg;
  always_comb
  begin
    ctlOut.normalEnable = ~mode_reg & ~resetNeeded_reg;
    ctlOut.data_input_reference = mode_reg;
    ctlOut.refreshHold = mode_reg;
    ctlOut.resetNeeded = resetNeeded_reg;
  end

  // ==========================================================
  // result network; clocking it would add cycles past the settle limit,
  // so data and enables take the pin path without flip-flops
  pplcm_terms u_terms (
    .pins(pins),
    .linkEnable(link_check_enable_in),
    .results(termResults)
  );

  // chip select gates every output at once, in parallel
  assign outputDrive = mode_reg & ~chipSelect_n;
  assign dqOe = {DQ_W{outputDrive}};
  assign strobeOe = {4{outputDrive}};
  assign resultOut = termResults;

  // ==========================================================
  // checks: mode sequencing
  entry_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(mode_reg) |-> $past(enSync2_reg, 1) && $past(enSync2_reg, 2)
      && $past(enSync2_reg, 3))
    else $error("mode entered before the entry delay");

  entry_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(enSync2_reg) ##0 enSync2_reg [*4] |-> mode_reg)
    else $error("mode not entered after steady enable");

  // the counter parks at the entry count; a wrap would re-arm the delay
  cnt_limit_a: assert property (@(posedge clk) disable iff (!reset_n)
    entryCnt_reg <= ENTRY_COUNT)
    else $error("entry counter past its limit");

  exit_fast_a: assert property (@(posedge clk) disable iff (!reset_n)
    !enSync2_reg |=> !mode_reg)
    else $error("mode held after enable dropped");

  normal_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    mode_reg |-> !ctlOut.normalEnable && ctlOut.refreshHold)
    else $error("normal function active during check mode");

  normal_back_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!mode_reg && !resetNeeded_reg) |-> ctlOut.normalEnable)
    else $error("normal function blocked outside check mode");

  // ==========================================================
  // checks: analog side controls
  // termination may come back in the very cycle the mode drops
  term_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    mode_reg |-> !termEnable_reg)
    else $error("termination on during check mode");

  term_early_a: assert property (@(posedge clk) disable iff (!reset_n)
    enSync2_reg |=> !termEnable_reg)
    else $error("termination on after enable seen");

  term_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!enSync2_reg && !mode_reg && termSync2_reg) |=> termEnable_reg)
    else $error("termination blocked outside check mode");

  ref_half_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctlOut.data_input_reference == link_check_mode)
    else $error("reference select disagrees with mode");

  refresh_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !mode_reg |-> !ctlOut.refreshHold && !ctlOut.data_input_reference)
    else $error("check mode controls active outside the mode");

  exit_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(mode_reg) |-> resetNeeded_reg && !ctlOut.normalEnable)
    else $error("exit not flagged for reset");

  flag_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
    resetNeeded_reg |=> resetNeeded_reg)
    else $error("exit flag cleared without reset");

  // ==========================================================
  // checks: result pins
  out_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (dqOe != '0 || strobeOe != '0) |-> mode_reg && !chipSelect_n)
    else $error("outputs driven outside gated window");

  out_float_a: assert property (@(posedge clk) disable iff (!reset_n)
    chipSelect_n |-> dqOe == '0 && strobeOe == '0)
    else $error("outputs driven with chip select high");

  oe_all_a: assert property (@(posedge clk) disable iff (!reset_n)
    (dqOe == {DQ_W{dqOe[0]}}) && (strobeOe == {4{dqOe[0]}}))
    else $error("output enables not switched together");

  dq_inverse_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.dq[DQ_W-1:HALF_DQ] == ~resultOut.dq[HALF_DQ-1:0])
    else $error("upper data byte not inverted");

  strobe_inv_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.upper_strobe != resultOut.lower_strobe
      && resultOut.upperStrobeC != resultOut.lowerStrobeC)
    else $error("upper strobes not inverted");

  // ==========================================================
  // checks: result terms, written from the pin equations, not the network
  term_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.dq[0] == (pins.addr[1] ^ pins.addr[6] ^ pins.ca_check_bit_in))
    else $error("term zero mismatch");

  term_one_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.dq[1] == (pins.addr[8] ^ pins.alertIn ^ pins.addr[9]))
    else $error("term one mismatch");

  term_two_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.dq[2] == (pins.addr[2] ^ pins.addr[5] ^ pins.addr[13]))
    else $error("term two mismatch");

  term_three_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.dq[3] == (pins.addr[0] ^ pins.addr[7] ^ pins.addr[11]))
    else $error("term three mismatch");

  term_four_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.dq[4] == (pins.clock_complement ^ pins.termination_control_in
      ^ pins.addr[15]))
    else $error("term four mismatch");

  term_five_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.dq[5] == (pins.cke ^ pins.addr[16] ^ pins.addr[10]))
    else $error("term five mismatch");

  term_six_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.dq[6] == (pins.row_open_cmd_in ^ pins.addr[4] ^ pins.bank_select_bits[1]))
    else $error("term six mismatch");

  term_seven_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.dq[7] == (pins.upper_byte_mask_in ^ pins.lower_byte_mask_in
      ^ pins.clockTrue))
    else $error("term seven mismatch");

  term_eight_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.lower_strobe == (pins.addr[14] ^ pins.addr[12] ^ pins.bank_select_bits[0]))
    else $error("term eight mismatch");

  term_nine_a: assert property (@(posedge clk) disable iff (!reset_n)
    resultOut.lowerStrobeC == (pins.bank_group_bit0 ^ pins.addr[3]
      ^ (pins.memResetIn & link_check_enable_in)))
    else $error("term nine mismatch");

  // ==========================================================
  // scenarios
  entry_c: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(mode_reg));

  exit_c: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(mode_reg));

  drive_c: cover property (@(posedge clk) disable iff (!reset_n)
    mode_reg && !chipSelect_n ##1 mode_reg && chipSelect_n);

  short_pulse_c: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(enSync2_reg) ##1 !enSync2_reg);

  float_c: cover property (@(posedge clk) disable iff (!reset_n)
    mode_reg && chipSelect_n);

endmodule : pplcm_top

// ===== hw/pplcm_pkg.sv
// Functional notes
// - test enable high bypasses memory function; pins become parallel test inputs and outputs
// - while in check mode the data input reference is forced to half supply
// - test outputs drive only while chip select is low, else float
// - termination stays off for the whole check mode regardless of its input
// - results follow inputs through fixed propagation delay, no clocking
// - all inputs applied and all outputs sampled in parallel
// - normal function pins are reused as test inputs during the mode
// - inputs grouped: command/address/clock, byte masks, alert, reset
// - results appear on sixteen data lines and both strobe pairs
// - test enable defaults low so a floating input never enters the mode
// - test enable has no effect on normal memory operation; here an enable seen high turns termination off before entry
// - only digital pins take part in the check
// - every sixteen-bit organisation supports the check mode
// - terms 0 to 4 are fixed three-input xor equations
// - terms 5 to 9 are fixed three-input xor equations
// - data high byte and upper strobes are inversions of low byte and lower strobes
// - entry at least 200 ns after enable; outputs valid within 200 ns
package pplcm_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int ENTRY_TIME_NS = 200;
  localparam int SETTLE_TIME_NS = 200;
  // least time rounds up, longest time rounds down
  localparam int ENTRY_CYCLES = (ENTRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES = SETTLE_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] ENTRY_COUNT = CNT_W'(ENTRY_CYCLES);

  // ==========================================================
  // field layout and reset values
  localparam int ADDR_W = 17;
  localparam int DQ_W = 16;
  localparam int TERM_W = 10;
  localparam int HALF_DQ = 8;
  localparam logic MODE_RST = 1'b0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] bank_select_bits;
    logic bank_group_bit0;
    logic [ADDR_W-1:0] addr;
    logic cke;
    logic row_open_cmd_in;
    logic termination_control_in;
    logic clockTrue;
    logic clock_complement;
    logic ca_check_bit_in;
    logic lower_byte_mask_in;
    logic upper_byte_mask_in;
    logic alertIn;
    logic memResetIn;
  } pplcm_pins_t;

  typedef struct packed {
    logic [DQ_W-1:0] dq;
    logic lower_strobe;
    logic lowerStrobeC;
    logic upper_strobe;
    logic upperStrobeC;
  } pplcm_results_t;

  typedef struct packed {
    logic normalEnable;
    logic data_input_reference;
    logic refreshHold;
    logic resetNeeded;
  } pplcm_ctl_t;

  // ==========================================================
  // three-input parity used by every result term
  function automatic logic xor3(input logic a, input logic b, input logic c);
    return a ^ b ^ c;
  endfunction : xor3

endpackage : pplcm_pkg

// ===== hw/pplcm_terms.sv
`timescale 1ns/10ps
module pplcm_terms
  import pplcm_pkg::*;
(
  // test pattern
  input pplcm_pins_t pins,
  input wire logic linkEnable,
  // results
  output pplcm_results_t results
);

  logic [TERM_W-1:0] resultTerm;

  // ==========================================================
  // result terms, purely combinational so patterns may follow back to back
  always_comb
  begin
    resultTerm[0] = xor3(pins.addr[1], pins.addr[6], pins.ca_check_bit_in);
    resultTerm[1] = xor3(pins.addr[8], pins.alertIn, pins.addr[9]);
    resultTerm[2] = xor3(pins.addr[2], pins.addr[5], pins.addr[13]);
    resultTerm[3] = xor3(pins.addr[0], pins.addr[7], pins.addr[11]);
    resultTerm[4] = xor3(pins.clock_complement, pins.termination_control_in,
                         pins.addr[15]);
    resultTerm[5] = xor3(pins.cke, pins.addr[16], pins.addr[10]);
    resultTerm[6] = xor3(pins.row_open_cmd_in, pins.addr[4],
                         pins.bank_select_bits[1]);
    resultTerm[7] = xor3(pins.upper_byte_mask_in, pins.lower_byte_mask_in,
                         pins.clockTrue);
    resultTerm[8] = xor3(pins.addr[14], pins.addr[12], pins.bank_select_bits[0]);
    // reset pin only counts while the enable is high
    resultTerm[9] = xor3(pins.bank_group_bit0, pins.addr[3],
                         pins.memResetIn & linkEnable);
  end

  // ==========================================================
  // output mapping: high byte and upper strobes are inverted copies
  always_comb
  begin
    results.dq[HALF_DQ-1:0] = resultTerm[HALF_DQ-1:0];
    results.dq[DQ_W-1:HALF_DQ] = ~resultTerm[HALF_DQ-1:0];
    results.lower_strobe = resultTerm[8];
    results.lowerStrobeC = resultTerm[9];
    results.upper_strobe = ~resultTerm[8];
    results.upperStrobeC = ~resultTerm[9];
  end

endmodule : pplcm_terms

// ===== tb/pplcm_agent.sv
`timescale 1ns/10ps
module pplcm_agent
  import pplcm_pkg::*;
(
  // clock and bench pattern
  input wire logic clk,
  input wire logic enable,
  input pplcm_pins_t pattern,
  // device side
  output pplcm_pins_t pins,
  input pplcm_results_t results,
  input wire logic [DQ_W-1:0] dqOe,
  input wire logic [3:0] strobeOe,
  // levels seen on the board
  output pplcm_results_t wireLevel
);
  pplcm_results_t last_reg = '0;
  logic [19:0] oeAll;

  // ==========================================================
  // pattern drive
  // all pins move at once; the clock pair never sits at one level
  always_comb
  begin
    pins = pattern;
    pins.clock_complement = ~pattern.clockTrue;
    pins.memResetIn = pattern.memResetIn | enable;
  end

  // ==========================================================
  // board wires
  // a released line shows the inverse of its last level, so a float never matches
  assign oeAll = {dqOe, strobeOe};
  assign wireLevel = (oeAll & results) | (~oeAll & ~last_reg);
  always @(posedge clk)
    last_reg <= wireLevel;
endmodule : pplcm_agent

// ===== tb/pplcm_top_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pplcm_top_test;
  import pplcm_pkg::*;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic link_check_enable_in = 1'b0;
  logic chipSelect_n = 1'b1;
  pplcm_pins_t pattern = '0;
  pplcm_pins_t pins;
  pplcm_results_t resultOut;
  pplcm_results_t wireLevel;
  logic [DQ_W-1:0] dqOe;
  logic [3:0] strobeOe;
  logic link_check_mode;
  logic terminationEnable;
  pplcm_ctl_t ctlOut;
  int fail_count = 0;
  int checks = 0;
  int seed = 72409;
  int n;

  // ==========================================================
  // instances
  pplcm_top u_dut (.clk(clk), .reset_n(reset_n),
    .link_check_enable_in(link_check_enable_in), .chipSelect_n(chipSelect_n),
    .pins(pins), .resultOut(resultOut), .dqOe(dqOe), .strobeOe(strobeOe),
    .link_check_mode(link_check_mode), .terminationEnable(terminationEnable),
    .ctlOut(ctlOut));
  pplcm_agent u_agent (.clk(clk), .enable(link_check_enable_in), .pattern(pattern),
    .pins(pins), .results(resultOut), .dqOe(dqOe), .strobeOe(strobeOe),
    .wireLevel(wireLevel));

  // 10 MHz clock
  initial
  begin
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // expected results, worked out bit by bit
  function automatic pplcm_results_t expect_res(input pplcm_pins_t p, input logic en);
    logic [16:0] a;
    logic [9:0] t;
    a = p.addr;
    t[0] = a[1] ^ a[6] ^ p.ca_check_bit_in;
    t[1] = a[8] ^ a[9] ^ p.alertIn;
    t[2] = a[2] ^ a[5] ^ a[13];
    t[3] = a[0] ^ a[7] ^ a[11];
    t[4] = p.clock_complement ^ p.termination_control_in ^ a[15];
    t[5] = p.cke ^ a[16] ^ a[10];
    t[6] = p.row_open_cmd_in ^ a[4] ^ p.bank_select_bits[1];
    t[7] = p.upper_byte_mask_in ^ p.lower_byte_mask_in ^ p.clockTrue;
    t[8] = a[14] ^ a[12] ^ p.bank_select_bits[0];
    t[9] = p.bank_group_bit0 ^ a[3] ^ (p.memResetIn & en);
    return {~t[7:0], t[7:0], t[8], t[9], ~t[8], ~t[9]};
  endfunction : expect_res

  task automatic finish_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // bounded wait for the mode flag, counting rising edges
  task automatic wait_mode(input logic v, input int bound, output int cnt);
    cnt = 0;
    while (link_check_mode !== v && cnt < bound)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (link_check_mode !== v)
    begin
      fail_count++;
      finish_test();
    end
  endtask : wait_mode

  // hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    // chip select low early: the outputs must still wait for the mode
    chipSelect_n = 1'b0;
    `CHK(link_check_mode, 1'b0)
    `CHK(ctlOut.normalEnable, 1'b1)
    `CHK({dqOe, strobeOe}, 20'h0_0000)
    pattern.termination_control_in = 1'b1;
    pattern.memResetIn = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(terminationEnable, 1'b1)
    link_check_enable_in = 1'b1;
    wait_mode(1'b1, 8, n);
    `CHK(n >= 3 && n <= 6, 1'b1)
    `CHK(terminationEnable, 1'b0)
    `CHK({ctlOut.data_input_reference, ctlOut.refreshHold, ctlOut.normalEnable}, 3'h6)
    // corners first, then random patterns changing every cycle
    for (int i = 0; i < 60; i++)
    begin
      @(negedge clk);
      chipSelect_n = i[1];
      pattern = (i < 2) ? {30{i[0]}} : 30'($random(seed));
      #1;
      `CHK(resultOut, expect_res(pins, 1'b1))
      `CHK({dqOe, strobeOe}, {20{~chipSelect_n}})
      if (!chipSelect_n) `CHK(wireLevel, expect_res(pins, 1'b1))
      `CHK(terminationEnable, 1'b0)
    end
    // exit leaves the device blocked until a full reset
    @(negedge clk);
    link_check_enable_in = 1'b0;
    wait_mode(1'b0, 4, n);
    `CHK(ctlOut.resetNeeded, 1'b1)
    repeat (4) @(negedge clk);
    `CHK(ctlOut.normalEnable, 1'b0)
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    `CHK(ctlOut.normalEnable, 1'b1)
    // a pulse shorter than the entry delay is refused
    link_check_enable_in = 1'b1;
    @(negedge clk);
    link_check_enable_in = 1'b0;
    repeat (8)
    begin
      @(negedge clk);
      `CHK(link_check_mode, 1'b0)
    end
    // reset pin high with the enable low must not reach term nine
    pattern.memResetIn = 1'b1;
    #1;
    `CHK(resultOut, expect_res(pins, 1'b0))
    finish_test();
  end
endmodule : pplcm_top_test
